// >>> rtl/rcl_reset_control.sv
// Notes on behaviour
// - external reset counts only after a low passes a two-stage synchroniser.
// - with no clock running, an external reset waits until clocking starts.
// - a synchronous reset is taken at the end of the current bus cycle.
// - reset outranks everything; work under way is aborted for good.
// - four outputs: pin drive, clock module, global internal, instruction.
// - all resets are clocked; asynchronous causes assert at the next edge.
// - synchronous resets wait for bus cycle end; bus monitor forced on.
// - power-up, watchdog, double-fault halt assert global, clock, pin lines.
// - pin and lost reference assert all three; test mode skips clock line.
// - reset instruction asserts only pin drive and the instruction flag.
// - byte and aligned word writes in flight finish before sync reset.
// - mode inputs captured and lines released before the processor starts.
// - handler address is vector base plus vector number times four.
// - processor start comes ten cycles after pin drive is released.
`timescale 1ns/1ps
module rcl_reset_control
    import rcl_pkg::*;
#(
    parameter int MODE_W = 16
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // reset causes
    input  wire logic              reset_pin_n,
    input  wire logic              power_up_detect,
    input  wire logic              watchdog_timeout,
    input  wire logic              double_fault_halt,
    input  wire logic              loss_of_reference,
    input  wire logic              test_mode_req,
    input  wire logic              reset_instr,
    // bus cycle status
    input  wire logic              bus_cycle_active,
    input  wire logic              bus_cycle_done,
    // configuration inputs
    input  wire logic [MODE_W-1:0] mode_select,
    input  wire logic [31:0]       vector_base_pointer,
    // reset lines
    output logic                   pin_drive_reset,
    output logic                   clock_module_reset,
    output logic                   global_internal_reset,
    output logic                   instruction_reset_flag,
    // bus and processor hand-off
    output logic                   bus_monitor_force,
    output logic                   processing_abort,
    output logic                   cpu_start,
    output logic [MODE_W-1:0]      mode_config,
    output logic [31:0]            reset_vector_addr
);

    function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                             input logic [7:0]  num);
        vec_addr = base + 32'(num) * 32'(VEC_BYTES);
    endfunction

    // synchroniser: stage one is read by stage two only
    logic ext_s1_q, ext_s1_d;
    logic ext_low_q, ext_low_d;

    always_comb begin
        ext_s1_d  = ~reset_pin_n;
        ext_low_d = ext_s1_q;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ext_s1_q  <= 1'b0;
            ext_low_q <= 1'b0;
        end else begin
            ext_s1_q  <= ext_s1_d;
            ext_low_q <= ext_low_d;
        end
    end

    // cause classes
    logic async_any, sync_any, clk_cause, src_any;
    always_comb begin
        async_any = power_up_detect | watchdog_timeout
                  | double_fault_halt;
        sync_any  = ext_low_q | loss_of_reference
                  | test_mode_req;
        clk_cause = async_any | ext_low_q
                  | loss_of_reference;
        src_any   = async_any | sync_any;
    end

    rcl_state_e        st_q, st_d;
    logic [3:0]        cnt_q, cnt_d;
    logic              pin_q, pin_d;
    logic              clk_q, clk_d;
    logic              glb_q, glb_d;
    logic              ins_q, ins_d;
    logic              mon_q, mon_d;
    logic              abt_q, abt_d;
    logic              go_q, go_d;
    logic [MODE_W-1:0] cfg_q, cfg_d;
    logic [31:0]       vad_q, vad_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        cfg_d = cfg_q;
        vad_d = vad_q;
        mon_d = 1'b0;
        abt_d = 1'b0;
        go_d  = 1'b0;
        glb_d = 1'b0;
        clk_d = 1'b0;
        pin_d = 1'b0;
        case (st_q)
            RCL_RUN: begin
                if (async_any) begin
                    st_d = RCL_RESET;
                end else if (sync_any && bus_cycle_active
                             && !bus_cycle_done) begin
                    // let the write finish; monitor ends a hung cycle
                    st_d  = RCL_WAIT_BUS;
                    mon_d = 1'b1;
                end else if (sync_any) begin
                    st_d = RCL_RESET;
                end
            end
            RCL_WAIT_BUS: begin
                mon_d = 1'b1;
                if (async_any || bus_cycle_done) begin
                    st_d  = RCL_RESET;
                    mon_d = 1'b0;
                end
            end
            RCL_RESET: begin
                if (!src_any) begin
                    st_d  = RCL_RELEASE;
                    cnt_d = 4'h0;
                    cfg_d = mode_select;
                end
            end
            RCL_RELEASE: begin
                if (async_any || sync_any) begin
                    st_d = RCL_RESET;
                end else if (cnt_q == FIRST_BUS_LAST) begin
                    st_d  = RCL_RUN;
                    go_d  = 1'b1;
                    vad_d = vec_addr(vector_base_pointer,
                                     RESET_VEC_NUM);
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            default: st_d = RCL_RUN;
        endcase
        if (st_d == RCL_RESET) begin
            glb_d = 1'b1;
            clk_d = clk_cause;
            pin_d = 1'b1;
            abt_d = (st_q != RCL_RESET);
        end
        // instruction reset bypasses the sequencer entirely
        ins_d = reset_instr;
        pin_d = pin_d | reset_instr;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q  <= RCL_RUN;
            cnt_q <= 4'h0;
            pin_q <= 1'b0;
            clk_q <= 1'b0;
            glb_q <= 1'b0;
            ins_q <= 1'b0;
            mon_q <= 1'b0;
            abt_q <= 1'b0;
            go_q  <= 1'b0;
            cfg_q <= '0;
            vad_q <= VEC_ADDR_RST;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            pin_q <= pin_d;
            clk_q <= clk_d;
            glb_q <= glb_d;
            ins_q <= ins_d;
            mon_q <= mon_d;
            abt_q <= abt_d;
            go_q  <= go_d;
            cfg_q <= cfg_d;
            vad_q <= vad_d;
        end
    end

    assign pin_drive_reset        = pin_q;
    assign clock_module_reset     = clk_q;
    assign global_internal_reset  = glb_q;
    assign instruction_reset_flag = ins_q;
    assign bus_monitor_force      = mon_q;
    assign processing_abort       = abt_q;
    assign cpu_start              = go_q;
    assign mode_config            = cfg_q;
    assign reset_vector_addr      = vad_q;

    // release watch for the checks: counts quiet cycles in release,
    // kept apart from cnt_q so a miscount there cannot hide itself
    logic [3:0] qn_q, qn_d;

    always_comb begin
        qn_d = 4'h0;
        if (st_q == RCL_RELEASE && !src_any) begin
            qn_d = qn_q + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            qn_q <= 4'h0;
        end else begin
            qn_q <= qn_d;
        end
    end

    // checks
    sequence s_waiting;
        st_q == RCL_WAIT_BUS && !bus_cycle_done && !async_any;
    endsequence

    sequence s_quiet_release;
        $fell(pin_drive_reset) && st_q == RCL_RELEASE
            ##9 (qn_q == FIRST_BUS_LAST && !src_any);
    endsequence

    property p_ext_sync;
        @(posedge clock) disable iff (!rstn)
        ext_low_q |-> $past(!reset_pin_n, 2);
    endproperty
    a_ext_sync: assert property (p_ext_sync)
        else $error("external reset seen without two-stage sampling");

    property p_async_lines;
        @(posedge clock) disable iff (!rstn)
        async_any |=> global_internal_reset && clock_module_reset
                      && pin_drive_reset;
    endproperty
    a_async_lines: assert property (p_async_lines)
        else $error("asynchronous cause did not assert three lines");

    property p_instr_only;
        @(posedge clock) disable iff (!rstn)
        reset_instr && !src_any && st_q == RCL_RUN |=>
            pin_drive_reset && instruction_reset_flag
            && !global_internal_reset && !clock_module_reset;
    endproperty
    a_instr_only: assert property (p_instr_only)
        else $error("reset instruction asserted wrong lines");

    property p_test_no_clk;
        @(posedge clock) disable iff (!rstn)
        st_q == RCL_RESET && test_mode_req && !async_any && !ext_low_q
            && !loss_of_reference |=>
            global_internal_reset && !clock_module_reset;
    endproperty
    a_test_no_clk: assert property (p_test_no_clk)
        else $error("test reset asserted clock module line");

    property p_wait_bus;
        @(posedge clock) disable iff (!rstn)
        s_waiting |=> bus_monitor_force && !global_internal_reset;
    endproperty
    a_wait_bus: assert property (p_wait_bus)
        else $error("sync reset taken before bus cycle end");

    property p_sync_deferred;
        @(posedge clock) disable iff (!rstn)
        st_q == RCL_RUN && sync_any && !async_any && bus_cycle_active
            && !bus_cycle_done |=> bus_monitor_force ##1 1'b1;
    endproperty
    a_sync_deferred: assert property (p_sync_deferred)
        else $error("bus monitor not forced for pending sync reset");

    property p_first_cycle;
        @(posedge clock) disable iff (!rstn)
        s_quiet_release |=> cpu_start;
    endproperty
    a_first_cycle: assert property (p_first_cycle)
        else $error("processor start not ten cycles after release");

    property p_start_gap;
        @(posedge clock) disable iff (!rstn)
        cpu_start |-> qn_q == 4'(FIRST_BUS_CYC);
    endproperty
    a_start_gap: assert property (p_start_gap)
        else $error("processor start without ten quiet release cycles");

    property p_start_clean;
        @(posedge clock) disable iff (!rstn)
        cpu_start |-> !global_internal_reset && !clock_module_reset
            && reset_vector_addr == $past(vector_base_pointer);
    endproperty
    a_start_clean: assert property (p_start_clean)
        else $error("processor started with bad state");

    property p_abort;
        @(posedge clock) disable iff (!rstn)
        $rose(global_internal_reset) |-> processing_abort;
    endproperty
    a_abort: assert property (p_abort)
        else $error("reset entry without abort pulse");

    property p_hold;
        @(posedge clock) disable iff (!rstn)
        st_q == RCL_RESET && src_any |=> global_internal_reset;
    endproperty
    a_hold: assert property (p_hold)
        else $error("reset line dropped while cause active");

endmodule

// >>> rtl/rcl_pkg.sv
package rcl_pkg;
    // vector table geometry
    localparam int          VEC_COUNT      = 256;
    localparam int          VEC_TABLE_SIZE = 1024;
    localparam int          VEC_BYTES      = VEC_TABLE_SIZE / VEC_COUNT;
    localparam logic [7:0]  RESET_VEC_NUM  = 8'h00;
    // first bus cycle after the pin drive is released, in clock cycles
    localparam int          FIRST_BUS_CYC  = 10;
    localparam logic [3:0]  FIRST_BUS_LAST = 4'(FIRST_BUS_CYC - 1);
    // reset values
    localparam logic [31:0] VEC_ADDR_RST   = 32'h0000_0000;

    typedef enum logic [1:0] {
        RCL_RUN,
        RCL_WAIT_BUS,
        RCL_RESET,
        RCL_RELEASE
    } rcl_state_e;
endpackage

// >>> verification/rcl_board_model.sv
`timescale 1ns/1ps
module rcl_board_model (
    // reset request from the bench
    input  wire logic        pin_req,
    input  wire logic [15:0] mode_value,
    // device side
    input  wire logic        pin_drive_reset,
    output logic             reset_pin_n,
    output logic [15:0]      mode_select
);
    // own pin drive kept out of the board level, else reset self-latches
    assign reset_pin_n = ~pin_req;
    // drivers let go with the pin; weak pull-ups then hold the lines high
    assign mode_select = pin_drive_reset ? mode_value : 16'hFFFF;
endmodule

// >>> verification/rcl_tb.sv
`timescale 1ns/1ps
module tb;
    import rcl_pkg::*;
    logic        clock, rstn, pin_req, loss, test_req, instr;
    logic        bus_act, bus_done, pin_n, g, c, p, flag, mon, abrt, start;
    logic [2:0]  acause;
    logic [15:0] mode_value, mode_sel, mode_cfg;
    logic [31:0] vbp, vaddr;
    int          fails, n_tests;

    rcl_board_model rcl_board_model_inst (
        .pin_req(pin_req), .mode_value(mode_value),
        .pin_drive_reset(p), .reset_pin_n(pin_n), .mode_select(mode_sel));

    rcl_reset_control rcl_reset_control_inst (
        .clock(clock), .rstn(rstn), .reset_pin_n(pin_n),
        .power_up_detect(acause[0]), .watchdog_timeout(acause[1]),
        .double_fault_halt(acause[2]), .loss_of_reference(loss),
        .test_mode_req(test_req), .reset_instr(instr),
        .bus_cycle_active(bus_act), .bus_cycle_done(bus_done),
        .mode_select(mode_sel), .vector_base_pointer(vbp),
        .pin_drive_reset(p), .clock_module_reset(c),
        .global_internal_reset(g), .instruction_reset_flag(flag),
        .bus_monitor_force(mon), .processing_abort(abrt),
        .cpu_start(start), .mode_config(mode_cfg),
        .reset_vector_addr(vaddr));

    task automatic chk(input string nm, input logic [31:0] e, got);
        n_tests++;
        if (got !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, got);
        end
    endtask

    task automatic lines(input logic [2:0] e);
        chk("lines", {29'h0, e}, {29'h0, g, c, p});
    endtask

    // lat: negedges from cause removal until the lines must be low
    task automatic release_chk(input int lat);
        int n;
        n = 0;
        repeat (lat) @(negedge clock);
        lines(3'h0);
        while (start !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk("start_delay", 32'h0000_000A, 32'(n));
        chk("vector", vbp, vaddr);
        chk("mode_cfg", {16'h0, mode_value}, {16'h0, mode_cfg});
        chk("data_free", 32'h0000_FFFF, {16'h0, mode_sel});
        @(negedge clock);
        chk("start_pulse", 32'h0, {31'h0, start});
    endtask

    task automatic test_async();
        for (int i = 0; i < 3; i++) begin
            mode_value = 16'hA5C3 ^ 16'(i);
            acause = 3'h1 << i;
            @(negedge clock);
            lines(3'h7);
            chk("abort", 32'h1, {31'h0, abrt});
            repeat (3) @(negedge clock);
            chk("abort_off", 32'h0, {31'h0, abrt});
            lines(3'h7);
            acause = 3'h0;
            release_chk(1);
        end
        $display("test_async done");
    endtask

    task automatic test_pin();
        mode_value = 16'h1234;
        pin_req = 1'b1;
        repeat (2) @(negedge clock);
        lines(3'h0);
        @(negedge clock);
        lines(3'h7);
        pin_req = 1'b0;
        release_chk(3);
        $display("test_pin done");
    endtask

    task automatic test_testmode();
        mode_value = 16'hF7FF;
        test_req = 1'b1;
        @(negedge clock);
        lines(3'h5);
        repeat (3) @(negedge clock);
        lines(3'h5);
        test_req = 1'b0;
        release_chk(1);
        $display("test_testmode done");
    endtask

    task automatic test_sync_bus();
        mode_value = 16'h0F0F;
        bus_act = 1'b1;
        loss = 1'b1;
        @(negedge clock);
        chk("monitor", 32'h1, {31'h0, mon});
        lines(3'h0);
        repeat (2) @(negedge clock);
        lines(3'h0);
        bus_done = 1'b1;
        @(negedge clock);
        bus_done = 1'b0;
        bus_act = 1'b0;
        lines(3'h7);
        chk("monitor_off", 32'h0, {31'h0, mon});
        chk("abort", 32'h1, {31'h0, abrt});
        loss = 1'b0;
        release_chk(1);
        $display("test_sync_bus done");
    endtask

    task automatic test_interrupt();
        mode_value = 16'h3C3C;
        bus_act = 1'b1;
        test_req = 1'b1;
        @(negedge clock);
        chk("monitor", 32'h1, {31'h0, mon});
        acause = 3'h2;
        @(negedge clock);
        lines(3'h7);
        chk("monitor_off", 32'h0, {31'h0, mon});
        {acause, test_req, bus_act} = 5'h00;
        @(negedge clock);
        lines(3'h0);
        repeat (4) @(negedge clock);
        loss = 1'b1;
        @(negedge clock);
        lines(3'h7);
        chk("abort", 32'h1, {31'h0, abrt});
        chk("no_start", 32'h0, {31'h0, start});
        loss = 1'b0;
        release_chk(1);
        $display("test_interrupt done");
    endtask

    task automatic test_instr();
        instr = 1'b1;
        @(negedge clock);
        lines(3'h1);
        chk("flag", 32'h1, {31'h0, flag});
        instr = 1'b0;
        @(negedge clock);
        lines(3'h0);
        chk("flag_off", 32'h0, {31'h0, flag});
        repeat (12) begin
            @(negedge clock);
            chk("no_start", 32'h0, {31'h0, start});
        end
        $display("test_instr done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // the whole sequence needs well under 400 cycles
    initial begin
        repeat (3000) @(posedge clock);
        fails++;
        report_and_stop();
    end

    initial begin
        fails = 0;
        n_tests = 0;
        {rstn, pin_req, loss, test_req, instr, bus_act, bus_done} = 7'h00;
        acause = 3'h0;
        mode_value = 16'hFFFF;
        vbp = 32'h0001_2400;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        test_async();
        test_pin();
        test_testmode();
        test_sync_bus();
        test_interrupt();
        test_instr();
        report_and_stop();
    end
endmodule
